//--- hw/bpa_defs.svh
// constants for the background / power precedence arbiter
`ifndef BPA_DEFS_SVH
`define BPA_DEFS_SVH
`define BPA_PREC_VS 2'h0
`define BPA_PREC_BG 2'h1
`define BPA_PREC_LP 2'h2
`define BPA_PREC_RSV 2'h3
`define BPA_TICK_MS 100
`define BPA_CLK_KHZ 10000
`define BPA_TICK_CYC (`BPA_TICK_MS * `BPA_CLK_KHZ)
`define BPA_TIMER_W 32
`define BPA_NTIMER 5
`define BPA_IDX_IDLE_A 0
`define BPA_IDX_IDLE_B 1
`define BPA_IDX_IDLE_C 2
`define BPA_IDX_STBY_Y 3
`define BPA_IDX_STBY_Z 4
`define BPA_PC_ACTIVE 3'h0
`define BPA_PC_IDLE_A 3'h1
`define BPA_PC_IDLE_B 3'h2
`define BPA_PC_IDLE_C 3'h3
`define BPA_PC_STBY_Y 3'h4
`define BPA_PC_STBY_Z 3'h5
`endif

//--- hw/bpa_pkg.sv
// types for the background / power precedence arbiter
package bpa_pkg;
   typedef enum logic [3:0] {
      BPA_ACTIVE = 4'h1,
      BPA_LOWPWR = 4'h2,
      BPA_BGRUN = 4'h4,
      BPA_BGSUSP = 4'h8
   } bpa_state_t;
endpackage : bpa_pkg

//--- hw/bpa_timer.sv
// one power condition inactivity timer in 100 ms ticks
`include "bpa_defs.svh"
module bpa_timer
   import bpa_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic enable,
   input wire logic activity,
   input wire logic [`BPA_TIMER_W-1:0] init,
   output logic expired
);
   logic [`BPA_TIMER_W-1:0] count;
   logic [`BPA_TIMER_W-1:0] next_count;
   logic next_expired;

   always_comb begin
      next_count = count;
      next_expired = expired;
      if (!enable || activity) begin
         next_count = '0;
         next_expired = 1'b0;
      end else if (tick && !expired) begin
         next_count = count + `BPA_TIMER_W'(1);
         if (next_count >= init)
            next_expired = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= '0;
         expired <= 1'b0;
      end else begin
         count <= next_count;
         expired <= next_expired;
      end
   end
endmodule : bpa_timer

//--- hw/bpa_arbiter.sv
// background function versus low power precedence arbiter
`include "bpa_defs.svh"
module bpa_arbiter
   import bpa_pkg::*;
#(
   parameter int TICK_CYC = `BPA_TICK_CYC
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [1:0] bg_power_priority_sel,
   input wire logic [`BPA_NTIMER-1:0] timer_enable,
   input wire logic [`BPA_NTIMER*`BPA_TIMER_W-1:0] timer_init,
   input wire logic scan_timer_expired,
   input wire logic scan_enable,
   input wire logic dev_bg_event,
   input wire logic dev_bg_enable,
   input wire logic host_cmd,
   input wire logic host_busy,
   input wire logic bg_done,
   input wire logic bg_allowed_lp,
   output logic [2:0] power_cond,
   output logic bg_run,
   output logic bg_suspend,
   output logic cmd_accept,
   output logic [1:0] prec_active
);
   bpa_state_t state;
   bpa_state_t next_state;
   logic [2:0] next_power_cond;
   logic next_bg_run;
   logic next_bg_suspend;
   logic next_cmd_accept;
   logic [1:0] next_prec_active;
   logic bg_pending;
   logic next_bg_pending;
   logic [31:0] tick_cnt;
   logic [31:0] next_tick_cnt;
   logic tick;
   logic [`BPA_NTIMER-1:0] expired;
   logic [2:0] best_pc;
   logic any_expired;
   logic bg_first;
   logic bg_trigger;

   // divider gives one tick per 100 ms
   always_comb begin
      next_tick_cnt = tick_cnt + 32'h1;
      if (tick_cnt >= 32'(TICK_CYC - 1))
         next_tick_cnt = '0;
   end
   assign tick = (tick_cnt == 32'(TICK_CYC - 1));

   // host traffic counts as activity and restarts all timers
   genvar gi;
   generate
      for (gi = 0; gi < `BPA_NTIMER; gi++) begin : g_tmr
         bpa_timer u_tmr (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .tick(tick),
            .enable(timer_enable[gi]),
            .activity(host_cmd | host_busy),
            .init(timer_init[gi*`BPA_TIMER_W +: `BPA_TIMER_W]),
            .expired(expired[gi])
         );
      end
   endgenerate

   // fixed priority, deepest condition first
   always_comb begin
      best_pc = `BPA_PC_ACTIVE;
      if (expired[`BPA_IDX_STBY_Z])
         best_pc = `BPA_PC_STBY_Z;
      else if (expired[`BPA_IDX_STBY_Y])
         best_pc = `BPA_PC_STBY_Y;
      else if (expired[`BPA_IDX_IDLE_C])
         best_pc = `BPA_PC_IDLE_C;
      else if (expired[`BPA_IDX_IDLE_B])
         best_pc = `BPA_PC_IDLE_B;
      else if (expired[`BPA_IDX_IDLE_A])
         best_pc = `BPA_PC_IDLE_A;
   end
   assign any_expired = |expired;

   // 00 folds into 01, reserved keeps the last good setting
   always_comb begin
      next_prec_active = prec_active;
      if (bg_power_priority_sel == `BPA_PREC_VS)
         next_prec_active = `BPA_PREC_BG;
      else if (bg_power_priority_sel != `BPA_PREC_RSV)
         next_prec_active = bg_power_priority_sel;
   end
   assign bg_first = (prec_active == `BPA_PREC_BG);
   assign bg_trigger = (scan_timer_expired && scan_enable) ||
                       (dev_bg_event && dev_bg_enable);

   always_comb begin
      next_state = state;
      next_power_cond = power_cond;
      next_bg_run = 1'b0;
      next_bg_suspend = 1'b0;
      next_cmd_accept = host_cmd;
      next_bg_pending = bg_pending | bg_trigger;
      case (state)
         BPA_ACTIVE: begin
            next_power_cond = `BPA_PC_ACTIVE;
            if (bg_pending && !host_cmd && !host_busy) begin
               next_state = BPA_BGRUN;
               next_bg_run = 1'b1;
            end else if (any_expired && !host_busy) begin
               next_state = BPA_LOWPWR;
               next_power_cond = best_pc;
            end
         end
         BPA_LOWPWR: begin
            next_power_cond = best_pc == `BPA_PC_ACTIVE ? power_cond : best_pc;
            if (host_cmd) begin
               next_state = BPA_ACTIVE;
               next_power_cond = `BPA_PC_ACTIVE;
            end else if (bg_first && bg_pending) begin
               next_state = BPA_BGRUN;
               next_bg_run = 1'b1;
               next_power_cond = `BPA_PC_ACTIVE;
            end else if (!bg_first && bg_pending && bg_allowed_lp && !host_busy) begin
               next_state = BPA_BGRUN;
               next_bg_run = 1'b1;
            end
         end
         BPA_BGRUN: begin
            next_bg_run = 1'b1;
            if (host_cmd) begin
               next_state = BPA_BGSUSP;
               next_bg_run = 1'b0;
               next_bg_suspend = 1'b1;
            end else if (!bg_first && any_expired && !bg_allowed_lp) begin
               next_state = BPA_LOWPWR;
               next_bg_run = 1'b0;
               next_bg_suspend = 1'b1;
               next_power_cond = best_pc;
            end else if (bg_done && !bg_trigger) begin
               next_bg_pending = 1'b0;
               next_bg_run = 1'b0;
               // in background-first, or low-power-first with bg_allowed_lp, expiry during work waits until here
               if (any_expired) begin
                  next_state = BPA_LOWPWR;
                  next_power_cond = best_pc;
               end else begin
                  next_state = BPA_ACTIVE;
               end
            end
         end
         BPA_BGSUSP: begin
            next_bg_suspend = 1'b1;
            if (!host_cmd && !host_busy) begin
               next_state = BPA_BGRUN;
               next_bg_suspend = 1'b0;
               next_bg_run = 1'b1;
            end
         end
         default: begin
            next_state = BPA_ACTIVE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= BPA_ACTIVE;
         power_cond <= `BPA_PC_ACTIVE;
         bg_run <= 1'b0;
         bg_suspend <= 1'b0;
         cmd_accept <= 1'b0;
         prec_active <= `BPA_PREC_BG;
         bg_pending <= 1'b0;
         tick_cnt <= '0;
      end else begin
         state <= next_state;
         power_cond <= next_power_cond;
         bg_run <= next_bg_run;
         bg_suspend <= next_bg_suspend;
         cmd_accept <= next_cmd_accept;
         prec_active <= next_prec_active;
         bg_pending <= next_bg_pending;
         tick_cnt <= next_tick_cnt;
      end
   end

   sequence s_dev_wake_req;
      state == BPA_LOWPWR && bg_first && dev_bg_event && dev_bg_enable && !host_cmd;
   endsequence
   // a command, a finish or a setting change while pending cancels the wake
   sequence s_wake_quiet;
      bg_first && !host_cmd && !bg_done;
   endsequence

   a_prec_zero_fold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      bg_power_priority_sel == `BPA_PREC_VS |=> prec_active == `BPA_PREC_BG)
      else $error("setting zero not folded to background-first");
   a_prec_no_rsv: assert property (@(posedge sys_clk) disable iff (!rst_n)
      prec_active != `BPA_PREC_RSV)
      else $error("reserved precedence adopted");
   a_cmd_suspends: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state == BPA_BGRUN && host_cmd |=> bg_suspend && !bg_run)
      else $error("host command did not suspend background");
   a_wake_bg: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state == BPA_LOWPWR && bg_first && bg_pending && !host_cmd
      |=> bg_run && power_cond == `BPA_PC_ACTIVE)
      else $error("background-first did not wake");
   a_dev_event: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_dev_wake_req ##1 s_wake_quiet |=> bg_run)
      else $error("device event did not wake");
   a_lp_no_wake: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state == BPA_LOWPWR && !bg_first && !host_cmd |=> power_cond != `BPA_PC_ACTIVE)
      else $error("low-power-first left low power");
   a_lp_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state == BPA_LOWPWR && !bg_first && (!bg_allowed_lp || host_busy) |=> !bg_run)
      else $error("background ran without all conditions");
   a_lp_timer_susp: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state == BPA_BGRUN && !bg_first && !host_cmd && any_expired && !bg_allowed_lp
      |=> bg_suspend && power_cond == $past(best_pc))
      else $error("low-power-first timer did not suspend");
   a_bg_finish_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state == BPA_BGRUN && bg_first && !host_cmd && !bg_done |=> bg_run)
      else $error("background-first abandoned work");
   a_done_enter: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state == BPA_BGRUN && bg_first && !host_cmd && bg_done && !bg_trigger && any_expired
      |=> power_cond == $past(best_pc))
      else $error("expired timer not entered after background");
endmodule : bpa_arbiter

//--- verification/bpa_host_model.sv
// host initiator model: one command cycle, then a busy stretch
module bpa_host_model (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic go,
   input wire logic [7:0] busy_len,
   output logic host_cmd,
   output logic host_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt;
   // changes only just after a rising edge, like a real initiator
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         host_cmd <= 1'h0;
         cnt <= 8'h00;
      end else begin
         host_cmd <= go;
         if (host_cmd)
            cnt <= busy_len;
         else if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
      end
   end
   assign host_busy = (cnt != 8'h00);
endmodule : bpa_host_model

//--- verification/tb.sv
// self-checking bench for the precedence arbiter
`include "bpa_defs.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [1:0] sel; logic [1:0] prec;} bpa_row_t;
   logic sys_clk, rst_n, scan_exp, scan_en, dev_ev, dev_en, bg_done, bg_ok, go;
   logic [1:0] sel, prec_active;
   logic [4:0] t_en;
   logic [159:0] t_init;
   logic [7:0] busy_len;
   logic [2:0] power_cond;
   logic bg_run, bg_suspend, cmd_accept, host_cmd, host_busy;
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;
   bpa_row_t rows [7] = '{'{2'h2, 2'h2}, '{2'h3, 2'h2}, '{2'h0, 2'h1}, '{2'h3, 2'h1},
      '{2'h1, 2'h1}, '{2'h2, 2'h2}, '{2'h1, 2'h1}};

   bpa_arbiter #(.TICK_CYC(4)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .bg_power_priority_sel(sel), .timer_enable(t_en), .timer_init(t_init),
      .scan_timer_expired(scan_exp), .scan_enable(scan_en), .dev_bg_event(dev_ev),
      .dev_bg_enable(dev_en), .host_cmd(host_cmd), .host_busy(host_busy),
      .bg_done(bg_done), .bg_allowed_lp(bg_ok), .power_cond(power_cond),
      .bg_run(bg_run), .bg_suspend(bg_suspend), .cmd_accept(cmd_accept),
      .prec_active(prec_active));
   bpa_host_model u_host (.sys_clk(sys_clk), .rst_n(rst_n), .go(go),
      .busy_len(busy_len), .host_cmd(host_cmd), .host_busy(host_busy));

   initial begin
      sys_clk = 1'h0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic wrap_up;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up

   task automatic check(input logic [2:0] got, input logic [2:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   function automatic logic [2:0] probe(input int k);
      case (k)
         0: probe = power_cond;
         1: probe = 3'(bg_run);
         default: probe = 3'(bg_suspend);
      endcase
   endfunction : probe

   // bounded wait on an output, then compare
   task automatic wait_sig(input int k, input logic [2:0] exp, input int max);
      int n;
      n = 0;
      while (probe(k) !== exp && n < max) begin
         @(negedge sys_clk);
         n++;
      end
      check(probe(k), exp);
   endtask : wait_sig

   // one host command; cmd_accept trails host_cmd by one cycle
   task automatic host(input logic [7:0] len);
      busy_len = len;
      go = 1'h1;
      @(negedge sys_clk);
      go = 1'h0;
      check(3'(cmd_accept), 3'h0);
      @(negedge sys_clk);
      check(3'(cmd_accept), 3'h1);
   endtask : host

   task automatic pulse_bg(input int k);
      if (k == 0) scan_exp = 1'h1;
      else if (k == 1) dev_ev = 1'h1;
      else bg_done = 1'h1;
      @(negedge sys_clk);
      scan_exp = 1'h0;
      dev_ev = 1'h0;
      bg_done = 1'h0;
   endtask : pulse_bg

   task automatic chk_reset;
      check(power_cond, `BPA_PC_ACTIVE);
      check(3'(bg_run), 3'h0);
      check(3'(bg_suspend), 3'h0);
      check(3'(prec_active), 3'h1);
   endtask : chk_reset

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         $display("BAD t=%0t run did not finish", $time);
         wrap_up();
      end
   end

   initial begin
      {rst_n, scan_exp, scan_en, dev_ev, dev_en, bg_done, bg_ok, go} = 8'h00;
      sel = 2'h1;
      t_en = 5'h00;
      t_init = {5{32'h00000001}};
      busy_len = 8'h00;
      repeat (3) @(negedge sys_clk);
      chk_reset();
      rst_n = 1'h1;
      foreach (rows[i]) begin
         sel = rows[i].sel;
         repeat (2) @(negedge sys_clk);
         check(3'(prec_active), 3'(rows[i].prec));
      end
      // background-first: both idle_a and standby_y expire, deeper wins
      {scan_en, dev_en, bg_ok} = 3'h7;
      t_en = 5'h09;
      wait_sig(0, `BPA_PC_STBY_Y, 100);
      pulse_bg(0);
      wait_sig(1, 3'h1, 3);
      check(power_cond, `BPA_PC_ACTIVE);
      host(8'h02);
      check(3'(bg_suspend), 3'h1);
      check(3'(bg_run), 3'h0);
      wait_sig(1, 3'h1, 8);
      repeat (30) @(negedge sys_clk);
      check(3'(bg_run), 3'h1);
      check(power_cond, `BPA_PC_ACTIVE);
      pulse_bg(2);
      wait_sig(0, `BPA_PC_STBY_Y, 3);
      pulse_bg(1);
      wait_sig(1, 3'h1, 3);
      check(power_cond, `BPA_PC_ACTIVE);
      pulse_bg(2);
      wait_sig(0, `BPA_PC_STBY_Y, 3);
      // low-power-first: standby forbids background, so no wake for it
      sel = 2'h2;
      bg_ok = 1'h0;
      pulse_bg(1);
      repeat (10) @(negedge sys_clk);
      check(3'(bg_run), 3'h0);
      check(power_cond, `BPA_PC_STBY_Y);
      host(8'h06);
      wait_sig(0, `BPA_PC_ACTIVE, 3);
      check(3'(bg_run), 3'h0);
      wait_sig(1, 3'h1, 12);
      wait_sig(2, 3'h1, 40);
      check(3'(bg_run), 3'h0);
      wait_sig(0, `BPA_PC_STBY_Y, 5);
      // second reset in mid-run
      rst_n = 1'h0;
      @(negedge sys_clk);
      chk_reset();
      rst_n = 1'h1;
      repeat (2) @(negedge sys_clk);
      check(power_cond, `BPA_PC_ACTIVE);
      check(3'(prec_active), 3'h2);
      check(3'(bg_run), 3'h0);
      wrap_up();
   end
endmodule : tb
